/* verilog/uub_bridge.sv */
// USB to UART bridge core: register slave, UART, suspend and reset pins
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "uub_defines.svh"
module uub_bridge #(
  parameter logic [15:0] VID = 16'h1a2b,  // Arbitrary value
  parameter logic [15:0] PID = 16'h3c4d,  // Arbitrary value
  parameter logic [15:0] REL = 16'h0200   // Arbitrary value
) (
  input  wire logic                 ref_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 ce_i,
  input  wire logic [7:0]           s_axi_awaddr_i,
  input  wire logic                 s_axi_awvalid_i,
  output logic                      s_axi_awready_o,
  input  wire logic [31:0]          s_axi_wdata_i,
  input  wire logic [3:0]           s_axi_wstrb_i,
  input  wire logic                 s_axi_wvalid_i,
  output logic                      s_axi_wready_o,
  output logic [1:0]                s_axi_bresp_o,
  output logic                      s_axi_bvalid_o,
  input  wire logic                 s_axi_bready_i,
  input  wire logic [7:0]           s_axi_araddr_i,
  input  wire logic                 s_axi_arvalid_i,
  output logic                      s_axi_arready_o,
  output logic [31:0]               s_axi_rdata_o,
  output logic [1:0]                s_axi_rresp_o,
  output logic                      s_axi_rvalid_o,
  input  wire logic                 s_axi_rready_i,
  input  wire uub_pkg::uub_usb_ev_s usb_ev_i,
  output logic                      usb_pullup_o,
  output logic                      usb_resume_o,
  input  wire logic                 rxd_i,
  output logic                      txd_o,
  input  wire logic                 cts_n_i,
  output logic                      rts_n_o,
  input  wire logic                 dsr_n_i,
  output logic                      dtr_n_o,
  input  wire logic                 dcd_n_i,
  input  wire logic                 ri_n_i,
  output logic                      suspend_o,
  output logic                      suspend_n_o,
  output logic                      suspend_oe_o,
  input  wire logic                 rst_pin_i,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe_o
);
  import uub_pkg::*;

  localparam int RST_CYC = (`UUB_RST_MIN_NS * (`UUB_CLK_HZ / 1000000) + 999) / 1000;

  // Bit period in clocks for each rate index
  function automatic logic [17:0] bdiv(input logic [4:0] i);
    case (i)
      5'h00:   bdiv = 18'(`UUB_CLK_HZ / 300);
      5'h01:   bdiv = 18'(`UUB_CLK_HZ / 600);
      5'h02:   bdiv = 18'(`UUB_CLK_HZ / 1200);
      5'h03:   bdiv = 18'(`UUB_CLK_HZ / 1800);
      5'h04:   bdiv = 18'(`UUB_CLK_HZ / 2400);
      5'h05:   bdiv = 18'(`UUB_CLK_HZ / 4800);
      5'h06:   bdiv = 18'(`UUB_CLK_HZ / 7200);
      5'h07:   bdiv = 18'(`UUB_CLK_HZ / 9600);
      5'h08:   bdiv = 18'(`UUB_CLK_HZ / 14400);
      5'h09:   bdiv = 18'(`UUB_CLK_HZ / 19200);
      5'h0a:   bdiv = 18'(`UUB_CLK_HZ / 28800);
      5'h0b:   bdiv = 18'(`UUB_CLK_HZ / 38400);
      5'h0c:   bdiv = 18'(`UUB_CLK_HZ / 56000);
      5'h0d:   bdiv = 18'(`UUB_CLK_HZ / 57600);
      5'h0e:   bdiv = 18'(`UUB_CLK_HZ / 115200);
      5'h0f:   bdiv = 18'(`UUB_CLK_HZ / 128000);
      5'h10:   bdiv = 18'(`UUB_CLK_HZ / 230400);
      5'h11:   bdiv = 18'(`UUB_CLK_HZ / 460800);
      default: bdiv = 18'(`UUB_CLK_HZ / 921600);
    endcase
  endfunction

  // Address decode shared by the write and read paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `UUB_A_CTRL) || (a == `UUB_A_STAT) || (a == `UUB_A_TXD) ||
             (a == `UUB_A_RXD) || (a == `UUB_A_DADR) || (a == `UUB_A_DDAT);
  endfunction

  // Built-in descriptor bytes returned while the store is blank
  function automatic logic [7:0] dflt(input logic [7:0] a);
    logic [7:0] k;
    k = a - `UUB_D_PROD;
    dflt = 8'h00;
    if (a == `UUB_D_VID) dflt = VID[7:0];
    else if (a == `UUB_D_VID + 8'h01) dflt = VID[15:8];
    else if (a == `UUB_D_PID) dflt = PID[7:0];
    else if (a == `UUB_D_PID + 8'h01) dflt = PID[15:8];
    else if (a == `UUB_D_ATTR) dflt = `UUB_DEF_ATTR;
    else if (a == `UUB_D_MAXP) dflt = `UUB_DEF_MAXP;
    else if (a == `UUB_D_REL) dflt = REL[7:0];
    else if (a == `UUB_D_REL + 8'h01) dflt = REL[15:8];
    else if (a == `UUB_D_SLEN) dflt = 8'h01;
    else if (a == `UUB_D_SER) dflt = `UUB_DEF_SER;
    else if (a == `UUB_D_PLEN) dflt = `UUB_DEF_PLEN;
    else if (k < `UUB_DEF_PLEN) dflt = 8'(`UUB_DEF_PROD >> (8'h18 - {k[4:0], 3'b000}));
  endfunction

  logic [5:0]  sync1;
  logic [5:0]  sync2;
  logic [9:0]  rst_cnt;
  logic        srst;
  uub_cfg_s    cfg;
  logic [17:0] div;
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        rd_fire;
  logic        suspended;
  logic        configured;
  logic [7:0]  tx_hold;
  logic        tx_full;
  uub_ser_e    tx_st;
  logic [17:0] tx_cnt;
  logic [2:0]  tx_bit;
  logic [7:0]  tx_sh;
  logic        tx_stall;
  uub_ser_e    rx_st;
  logic [17:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_sh;
  logic        rx_perr;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_done;
  logic        xoff_held;
  logic [2:0]  err;
  logic [7:0]  desc_addr;
  logic [7:0]  store [256];
  logic        store_prog;
  logic [7:0]  ddat;
  logic        rxd_s;
  logic        pin_s;

  assign rxd_s    = sync2[0];
  assign pin_s    = sync2[5];
  assign div      = bdiv(cfg.rate);
  assign wr_fire  = aw_got && w_got && !s_axi_bvalid_o;
  assign rd_fire  = s_axi_arvalid_i && s_axi_arready_o;
  assign tx_stall = (cfg.rts_fc && sync2[1]) || (cfg.dtr_fc && sync2[2]) || xoff_held;
  assign rx_done  = rx_st == UUB_STOP && rx_cnt == 18'h0;
  assign ddat     = s_axi_wdata_i[7:0];

  // Two-stage synchronisers for every pin input; idle level is high
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= 6'h3f;
      sync2 <= 6'h3f;
    end else if (ce_i) begin
      sync1 <= {rst_pin_i, ri_n_i, dcd_n_i, dsr_n_i, cts_n_i, rxd_i};
      sync2 <= sync1;
    end
  end

  // Reset pin: qualified low for the minimum time gives a device reset
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_cnt <= 10'h0;
      srst    <= 1'b0;
    end else if (ce_i) begin
      if (pin_s) begin
        rst_cnt <= 10'h0;
        srst    <= 1'b0;
      end else if (rst_cnt < 10'(RST_CYC - 1)) begin
        rst_cnt <= rst_cnt + 10'h1;
      end else begin
        srst <= 1'b1;
      end
    end
  end

  // Power-on reset drives the open-drain pin low until release
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_pin_o    <= 1'b0;
      rst_pin_oe_o <= 1'b1;
    end else if (ce_i) begin
      rst_pin_o    <= 1'b0;
      rst_pin_oe_o <= 1'b0;
    end
  end

  // Write address and data are taken in either order, answered together
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_got <= 1'b0;
      w_got  <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `UUB_RESP_OK;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got  <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= mapped(aw_addr) ? `UUB_RESP_OK : `UUB_RESP_ERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o  <= 1'b0;
        aw_got <= 1'b0;
        w_got  <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
      end
    end
  end

  // Configuration from host commands; resume request never stays set
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg <= uub_cfg_s'(`UUB_CTRL_RST);
      usb_resume_o <= 1'b0;
    end else if (ce_i) begin
      usb_resume_o <= 1'b0;
      if (srst) begin
        cfg <= uub_cfg_s'(`UUB_CTRL_RST);
      end else if (wr_fire && aw_addr == `UUB_A_CTRL && w_strb[0] && w_strb[1]) begin
        cfg <= uub_cfg_s'({1'b0, w_data[11:0]});
        usb_resume_o <= w_data[12] && suspended;
      end
    end
  end

  // Read channel; side effects happen when the address is taken
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= `UUB_RESP_OK;
    end else if (ce_i) begin
      if (rd_fire) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? `UUB_RESP_OK : `UUB_RESP_ERR;
        s_axi_rdata_o   <= 32'h0;
        if (s_axi_araddr_i == `UUB_A_CTRL) s_axi_rdata_o <= {19'h0, cfg};
        else if (s_axi_araddr_i == `UUB_A_STAT) begin
          s_axi_rdata_o <= {19'h0, store_prog, xoff_held, configured, suspended,
                            ~sync2[4], ~sync2[3], ~sync2[2], ~sync2[1], err,
                            rx_valid, tx_full || tx_st != UUB_IDLE};
        end
        else if (s_axi_araddr_i == `UUB_A_RXD) s_axi_rdata_o <= {24'h0, rx_data};
        else if (s_axi_araddr_i == `UUB_A_DADR) s_axi_rdata_o <= {24'h0, desc_addr};
        else if (s_axi_araddr_i == `UUB_A_DDAT) begin
          s_axi_rdata_o <= {24'h0, store_prog ? store[desc_addr] : dflt(desc_addr)};
        end
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // Suspend state follows USB events; device reset exits and unconfigures
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      suspended  <= 1'b0;
      configured <= 1'b0;
    end else if (ce_i) begin
      if (srst) begin
        suspended  <= 1'b0;
        configured <= 1'b0;
      end else begin
        if (usb_ev_i.configured) configured <= 1'b1;
        if (usb_ev_i.resume || usb_ev_i.bus_rst || usb_resume_o) suspended <= 1'b0;
        else if (usb_ev_i.suspend) suspended <= 1'b1;
      end
    end
  end

  // Suspend pins: released while in reset so the board pull-ups win
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      suspend_o    <= 1'b1;
      suspend_n_o  <= 1'b1;
      suspend_oe_o <= 1'b0;
      usb_pullup_o <= 1'b0;
    end else if (ce_i) begin
      suspend_o    <= suspended || !configured;
      suspend_n_o  <= !(suspended || !configured);
      suspend_oe_o <= !srst;
      usb_pullup_o <= !srst;
    end
  end

  // Transmit holding register: one byte waits while a character is on the line
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_hold <= 8'h0;
      tx_full <= 1'b0;
    end else if (ce_i) begin
      if (srst) begin
        tx_full <= 1'b0;
      end else if (wr_fire && aw_addr == `UUB_A_TXD && w_strb[0] && !tx_full) begin
        tx_hold <= w_data[7:0];
        tx_full <= 1'b1;
      end else if (tx_st == UUB_IDLE && !tx_stall) begin
        tx_full <= 1'b0;
      end
    end
  end

  // Transmitter: start, eight data bits lsb first, optional parity, one stop
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st  <= UUB_IDLE;
      tx_cnt <= 18'h0;
      tx_bit <= 3'h0;
      tx_sh  <= 8'h0;
      txd_o  <= 1'b1;
    end else if (ce_i) begin
      if (srst) begin
        tx_st <= UUB_IDLE;
        txd_o <= 1'b1;
      end else if (tx_st == UUB_IDLE) begin
        if (tx_full && !tx_stall) begin
          tx_sh  <= tx_hold;
          tx_st  <= UUB_START;
          tx_cnt <= div - 18'h1;
          txd_o  <= 1'b0;
        end
      end else if (tx_cnt != 18'h0) begin
        tx_cnt <= tx_cnt - 18'h1;
      end else begin
        tx_cnt <= div - 18'h1;
        case (tx_st)
          UUB_START: begin
            tx_st  <= UUB_DATA;
            tx_bit <= 3'h0;
            txd_o  <= tx_sh[0];
          end
          UUB_DATA: begin
            if (tx_bit == 3'h7) begin
              tx_st <= (cfg.par == UUB_PAR_NONE) ? UUB_STOP : UUB_PAR;
              txd_o <= (cfg.par == UUB_PAR_NONE) ? 1'b1
                     : ((^tx_sh) ^ (cfg.par == UUB_PAR_ODD));
            end else begin
              tx_bit <= tx_bit + 3'h1;
              txd_o  <= tx_sh[tx_bit + 3'h1];
            end
          end
          UUB_PAR: begin
            tx_st <= UUB_STOP;
            txd_o <= 1'b1;
          end
          default: begin
            tx_st <= UUB_IDLE;
            txd_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // Receiver: confirm start at mid-bit, then sample each bit at its centre
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st   <= UUB_IDLE;
      rx_cnt  <= 18'h0;
      rx_bit  <= 3'h0;
      rx_sh   <= 8'h0;
      rx_perr <= 1'b0;
    end else if (ce_i) begin
      if (srst) begin
        rx_st <= UUB_IDLE;
      end else if (rx_st == UUB_IDLE) begin
        if (!rxd_s) begin
          rx_st  <= UUB_START;
          rx_cnt <= {1'b0, div[17:1]};
        end
      end else if (rx_cnt != 18'h0) begin
        rx_cnt <= rx_cnt - 18'h1;
      end else begin
        rx_cnt <= div - 18'h1;
        case (rx_st)
          UUB_START: begin
            rx_st   <= rxd_s ? UUB_IDLE : UUB_DATA;  // Glitch rejection
            rx_bit  <= 3'h0;
            rx_perr <= 1'b0;
          end
          UUB_DATA: begin
            rx_sh  <= {rxd_s, rx_sh[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) rx_st <= (cfg.par == UUB_PAR_NONE) ? UUB_STOP : UUB_PAR;
          end
          UUB_PAR: begin
            rx_perr <= rxd_s != ((^rx_sh) ^ (cfg.par == UUB_PAR_ODD));
            rx_st   <= UUB_STOP;
          end
          default: rx_st <= UUB_IDLE;
        endcase
      end
    end
  end

  // Received byte delivery and in-band flow control; set wins over the read
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_data   <= 8'h0;
      rx_valid  <= 1'b0;
      xoff_held <= 1'b0;
    end else if (ce_i) begin
      if (srst) begin
        rx_valid  <= 1'b0;
        xoff_held <= 1'b0;
      end else begin
        // Read clears first, so a consumed XON or XOFF cannot swallow it
        if (rd_fire && s_axi_araddr_i == `UUB_A_RXD) rx_valid <= 1'b0;
        if (rx_done && cfg.xon_en && rx_sh == `UUB_XOFF) begin
          xoff_held <= 1'b1;
        end else if (rx_done && cfg.xon_en && rx_sh == `UUB_XON) begin
          xoff_held <= 1'b0;
        end else if (rx_done) begin
          rx_data  <= rx_sh;
          rx_valid <= 1'b1;
        end
      end
      if (!cfg.xon_en) xoff_held <= 1'b0;
    end
  end

  // Sticky receive errors, cleared by writing one; a new error wins
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err <= 3'h0;
    end else if (ce_i) begin
      if (srst) begin
        err <= 3'h0;
      end else begin
        if (wr_fire && aw_addr == `UUB_A_STAT && w_strb[0]) begin
          err <= err & ~w_data[`UUB_S_OVR:`UUB_S_PERR];
        end
        if (rx_done && rx_perr) err[0] <= 1'b1;
        if (rx_done && !rxd_s) err[1] <= 1'b1;
        if (rx_done && rx_valid && !(rd_fire && s_axi_araddr_i == `UUB_A_RXD)) err[2] <= 1'b1;
      end
    end
  end

  // Modem outputs: inactive high from reset until set, or driven by flow control
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else if (ce_i) begin
      rts_n_o <= srst || (cfg.rts_fc ? rx_valid : !cfg.rts_on);
      dtr_n_o <= srst || (cfg.dtr_fc ? rx_valid : !cfg.dtr_on);
    end
  end

  // Descriptor pointer steps after each data access
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      desc_addr <= 8'h0;
    end else if (ce_i) begin
      if (wr_fire && aw_addr == `UUB_A_DADR && w_strb[0]) desc_addr <= w_data[7:0];
      else begin
        desc_addr <= desc_addr + {7'h0, wr_fire && aw_addr == `UUB_A_DDAT}
                   + {7'h0, rd_fire && s_axi_araddr_i == `UUB_A_DDAT};
      end
    end
  end

  // Descriptor store survives device reset; only power-on clears the flag
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      store_prog <= 1'b0;
    end else if (ce_i && wr_fire && aw_addr == `UUB_A_DDAT && w_strb[0]) begin
      store_prog <= 1'b1;
    end
  end

  // Store array; length bytes are clamped to the string capacity
  always_ff @(posedge ref_clk_i) begin
    if (ce_i && wr_fire && aw_addr == `UUB_A_DDAT && w_strb[0]) begin
      if (desc_addr == `UUB_D_SLEN && w_data[7:0] > `UUB_SER_MAX) store[desc_addr] <= `UUB_SER_MAX;
      else if (desc_addr == `UUB_D_PLEN && w_data[7:0] > `UUB_PROD_MAX) begin
        store[desc_addr] <= `UUB_PROD_MAX;
      end else store[desc_addr] <= w_data[7:0];
    end
  end
endmodule

/* inc/uub_defines.svh */
// Constants for the USB to UART bridge
`ifndef UUB_DEFINES_SVH
`define UUB_DEFINES_SVH
`define UUB_CLK_HZ      40000000
`define UUB_RST_MIN_NS  15000
`define UUB_A_CTRL      8'h00
`define UUB_A_STAT      8'h04
`define UUB_A_TXD       8'h08
`define UUB_A_RXD       8'h0c
`define UUB_A_DADR      8'h10
`define UUB_A_DDAT      8'h14
`define UUB_CTRL_RST    13'h0038
`define UUB_S_PERR      2
`define UUB_S_FERR      3
`define UUB_S_OVR       4
`define UUB_XON         8'h11
`define UUB_XOFF        8'h13
`define UUB_D_VID       8'h00
`define UUB_D_PID       8'h02
`define UUB_D_ATTR      8'h04
`define UUB_D_MAXP      8'h05
`define UUB_D_REL       8'h06
`define UUB_D_SLEN      8'h08
`define UUB_D_SER       8'h09
`define UUB_D_PLEN      8'h48
`define UUB_D_PROD      8'h49
`define UUB_DEF_ATTR    8'h80
`define UUB_DEF_MAXP    8'h0f
`define UUB_SER_MAX     8'h3f
`define UUB_PROD_MAX    8'h7e
`define UUB_DEF_SER     8'h41
`define UUB_DEF_PROD    32'h55415254
`define UUB_DEF_PLEN    8'h04
`define UUB_RESP_OK     2'b00
`define UUB_RESP_ERR    2'b10
`endif

/* inc/uub_pkg.sv */
// Types shared by the USB to UART bridge
package uub_pkg;
  typedef enum logic [1:0] {UUB_PAR_NONE, UUB_PAR_EVEN, UUB_PAR_ODD} uub_par_e;
  typedef enum logic [2:0] {UUB_IDLE, UUB_START, UUB_DATA, UUB_PAR, UUB_STOP} uub_ser_e;
  // Serial configuration as written by the host, msb first
  typedef struct packed {
    logic       resume_req;
    logic       dtr_on;
    logic       rts_on;
    logic       xon_en;
    logic       dtr_fc;
    logic       rts_fc;
    logic [4:0] rate;
    uub_par_e   par;
  } uub_cfg_s;
  // Events from the USB serial engine, one-cycle pulses
  typedef struct packed {
    logic suspend;
    logic resume;
    logic bus_rst;
    logic configured;
  } uub_usb_ev_s;
endpackage

/* tb/uub_bridge_props.sv */
// Port-level checker for the bridge, bound to its top module
`timescale 1ns/1ps
module uub_bridge_props (
  input wire logic                 ref_clk_i,
  input wire logic                 rstn_i,
  input wire uub_pkg::uub_usb_ev_s usb_ev_i,
  input wire logic                 s_axi_awvalid_i,
  input wire logic                 s_axi_awready_o,
  input wire logic                 s_axi_wvalid_i,
  input wire logic                 s_axi_wready_o,
  input wire logic                 s_axi_bvalid_o,
  input wire logic                 s_axi_arvalid_i,
  input wire logic                 s_axi_arready_o,
  input wire logic                 s_axi_rvalid_o,
  input wire logic                 usb_pullup_o,
  input wire logic                 usb_resume_o,
  input wire logic                 txd_o,
  input wire logic                 suspend_o,
  input wire logic                 suspend_n_o,
  input wire logic                 suspend_oe_o
);
  import uub_pkg::*;
  logic cfg_seen; // Enumeration done since the last reset
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Any reset drops the pull-up, so the configuration is forgotten too
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_seen <= 1'b0;
    end else begin
      cfg_seen <= usb_pullup_o && (cfg_seen || usb_ev_i.configured);
    end
  end
  a_susp_pair:
    assert property (suspend_oe_o |-> suspend_n_o != suspend_o) else $error("pins not paired");
  a_susp_enter:
    assert property (usb_ev_i.suspend && !usb_ev_i.resume && !usb_ev_i.bus_rst && usb_pullup_o
      |-> ##2 suspend_o && !suspend_n_o) else $error("suspend not shown");
  a_susp_exit:
    assert property ((usb_ev_i.resume || usb_ev_i.bus_rst) && cfg_seen && usb_pullup_o
      |-> ##[1:2] !suspend_o) else $error("suspend not left");
  a_resume_exit:
    assert property (usb_resume_o && cfg_seen |-> ##2 !suspend_o && suspend_n_o)
      else $error("generated resume not left");
  a_rel_pin:
    assert property (!usb_pullup_o |-> !suspend_oe_o) else $error("pins driven in reset");
  a_tx_start:
    assert property ($fell(txd_o) |=> !txd_o [*8]) else $error("start bit too short");
  a_wr_stall:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write taken while pending");
  a_wr_answer:
    assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##2 s_axi_bvalid_o) else $error("late write answer");
  a_rd_answer:
    assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("late read answer");
  c_suspend: cover property (usb_ev_i.suspend ##2 suspend_o);
  c_tx: cover property ($fell(txd_o));
  c_pin_rst: cover property ($fell(usb_pullup_o));
endmodule
bind uub_bridge uub_bridge_props i_props (.*);

/* tb/uub_peer.sv */
// Serial peer model: frames bytes onto rxd and captures frames from txd
`timescale 1ns/1ps
module uub_peer #(
  parameter int BIT = 43
) (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      cts_n_o,
  output logic      dsr_n_o
);
  // Line idles high; handshake lines held asserted so nothing stalls
  initial begin
    {rxd_o, cts_n_o, dsr_n_o} = 3'h4;
  end
  // Start bit, lsb first, parity if any, one stop; bad flips the parity
  task automatic send(input logic [7:0] d, input int p, input logic bad);
    logic [10:0] f;
    f = p ? {1'b1, ^d ^ (p == 2) ^ bad, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < (p ? 11 : 10); i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
  // Sample each bit at its middle, start bit first
  task automatic recv(input int n, output logic [10:0] f);
    f = '0;
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      f[i] = txd_i;
      repeat (BIT) @(posedge clk_i);
    end
  endtask
endmodule

/* tb/test_usb_uart_bridge.sv */
// Self-checking bench for the USB to UART bridge
`timescale 1ns/1ps
module test_usb_uart_bridge;
  import uub_pkg::*;
  logic        ref_clk_i, rstn_i, ce_i, rxd_i, txd_o, cts_n_i, rts_n_o, dsr_n_i, dtr_n_o;
  logic        dcd_n_i, ri_n_i, suspend_o, suspend_n_o, suspend_oe_o, usb_pullup_o;
  logic        usb_resume_o, rst_pin_i, rst_pin_o, rst_pin_oe_o, s_axi_awvalid_i;
  logic        s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
  logic        s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, d;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, r;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [10:0] f;
  uub_usb_ev_s usb_ev_i;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [4:0]  evt [6] = '{5'h01, 5'h18, 5'h04, 5'h18, 5'h02, 5'h18}; // Expected pin, event
  uub_bridge i_dut (.*);
  uub_peer #(.BIT(40000000 / 921600)) i_peer (.clk_i(ref_clk_i), .txd_i(txd_o), .rxd_o(rxd_i),
    .cts_n_o(cts_n_i), .dsr_n_o(dsr_n_i));
  // 40 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One register access; a spare edge afterwards keeps the next request clean
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int t;
    t = 0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} <= {a, a, v};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= {3{w}};
    {s_axi_arvalid_i, s_axi_rready_i} <= {2{!w}};
    do begin
      @(posedge ref_clk_i);
      t++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      rs = w ? s_axi_bresp_o : s_axi_rresp_o;
      r = s_axi_rdata_o;
    end while (!(w ? s_axi_bvalid_o : s_axi_rvalid_o));
    {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
    @(posedge ref_clk_i);
    chk(32'(t), w ? 32'h3 : 32'h2);
  endtask
  function automatic logic [10:0] frame(logic [7:0] v, int p);
    return p ? {1'b1, ^v ^ (p == 2), v, 1'b0} : {2'b01, v, 1'b0};
  endfunction
  // Hang guard, far beyond the few thousand cycles the sequence needs
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    close_out;
  end
  // Main sequence
  initial begin
    void'($urandom(98));
    {ce_i, rst_pin_i, s_axi_wstrb_i, rstn_i, usb_ev_i} = 11'h7e0;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
    {dcd_n_i, ri_n_i} = 2'($urandom);
    repeat (3) @(posedge ref_clk_i);
    chk({rst_pin_oe_o, rst_pin_o, suspend_oe_o, rts_n_o, dtr_n_o, txd_o, usb_pullup_o}, 32'h4e);
    rstn_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    chk({suspend_o, suspend_n_o, suspend_oe_o, usb_pullup_o, rst_pin_oe_o}, 32'h16);
    bus(0, 8'h00, 0);
    chk(r, 32'h38);
    bus(1, 8'h10, 32'h4);
    chk(rs, 32'h0);
    bus(0, 8'h14, 0);
    chk(r, 32'h80);
    bus(0, 8'h14, 0);
    chk(r, 32'h0f);
    bus(0, 8'h18, 0);
    chk(rs, 32'h2);
    bus(1, 8'h18, 0);
    chk(rs, 32'h2);
    for (int i = 0; i < 6; i++) begin
      usb_ev_i <= uub_usb_ev_s'(evt[i][3:0]);
      @(posedge ref_clk_i);
      usb_ev_i <= '0;
      repeat (3) @(posedge ref_clk_i);
      chk({suspend_o, suspend_n_o}, evt[i][4] ? 32'h2 : 32'h1);
    end
    bus(1, 8'h00, 32'h1048);
    repeat (3) @(posedge ref_clk_i);
    chk(suspend_o, 32'h0);
    for (int p = 0; p < 3; p++) begin
      d = p ? 8'($urandom) : 8'hff;
      bus(1, 8'h00, 32'h48 | p);
      fork
        i_peer.recv(p ? 11 : 10, f);
        bus(1, 8'h08, {24'h0, d});
      join
      chk(f, frame(d, p));
      i_peer.send(d, p, p == 2);
      repeat (50) @(posedge ref_clk_i);
      bus(0, 8'h04, 0);
      chk({r[8:5], r[2:1]}, {~ri_n_i, ~dcd_n_i, 2'b11, p == 2, 1'b1});
      bus(0, 8'h0c, 0);
      chk(r, {24'h0, d});
    end
    bus(1, 8'h00, 32'hc48);
    repeat (3) @(posedge ref_clk_i);
    chk({rts_n_o, dtr_n_o}, 32'h0);
    // Serial length above capacity is clamped, and must outlive a device reset
    bus(1, 8'h10, 32'h8);
    bus(1, 8'h14, 32'h50);
    rst_pin_i <= 1'b0;
    repeat (700) @(posedge ref_clk_i);
    chk({usb_pullup_o, suspend_oe_o}, 32'h0);
    rst_pin_i <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    chk({suspend_o, suspend_n_o, rts_n_o, dtr_n_o, usb_pullup_o}, 32'h17);
    bus(1, 8'h10, 32'h8);
    bus(0, 8'h14, 0);
    chk(r, 32'h3f);
    bus(0, 8'h04, 0);
    chk(r[12], 32'h1);
    // Clock enable low freezes the pin qualifier, so no reset may follow
    ce_i <= 1'b0;
    rst_pin_i <= 1'b0;
    repeat (700) @(posedge ref_clk_i);
    chk(usb_pullup_o, 32'h1);
    {ce_i, rst_pin_i} <= 2'h3;
    close_out;
  end
endmodule
